// ==== logic/cibs_pkg.sv ====
package cibs_pkg;
    // special function register addresses
    localparam logic [7:0] CIBS_CTRL_ADDR   = 8'ha3;
    localparam logic [7:0] CIBS_STATUS_ADDR = 8'ha4;
    localparam logic [7:0] CIBS_IND_ADDR    = 8'ha5;
    localparam logic [7:0] CIBS_TEC_ADDR    = 8'ha6;
    localparam logic [7:0] CIBS_REC_ADDR    = 8'ha7;
    // message memory layout
    localparam logic [7:0] CIBS_MEM_PROT_LIM = 8'h10;
    localparam logic [7:0] CIBS_BT0_ADDR     = 8'h04;
    localparam logic [7:0] CIBS_BT1_ADDR     = 8'h05;
    // control register fields
    localparam int CIBS_C_ERR_IE   = 7;
    localparam int CIBS_C_STAT_IE  = 6;
    localparam int CIBS_C_PWRDN    = 5;
    localparam int CIBS_C_SOFT_RST = 3;
    localparam int CIBS_C_ABAUD    = 2;
    localparam int CIBS_C_CNT_SEL  = 1;
    localparam int CIBS_C_SWI      = 0;
    // status register fields
    localparam int CIBS_S_BOFF   = 7;
    localparam int CIBS_S_EXCEED = 6;
    localparam int CIBS_S_WAKE   = 5;
    localparam int CIBS_S_RX     = 4;
    localparam int CIBS_S_TX     = 3;
    // reset values
    localparam logic [7:0] CIBS_CTRL_RST = 8'h08;
    localparam logic [7:0] CIBS_IND_NONE = 8'h00;
    localparam logic [7:0] CIBS_IND_STAT = 8'h01;
    // error count thresholds
    localparam logic [8:0] CIBS_TEC_BOFF = 9'h100;
    localparam logic [8:0] CIBS_LIM0_SET = 9'h061;
    localparam logic [8:0] CIBS_LIM0_CLR = 9'h060;
    localparam logic [8:0] CIBS_LIM1     = 9'h080;
    // recessive run lengths and bus-off group count
    localparam int CIBS_IDLE_BITS  = 11;
    localparam int CIBS_BOFF_GROUPS = 128;
    // bus side states
    typedef enum logic [4:0] {
        CIBS_S_INIT = 5'b00001,
        CIBS_S_SYNC = 5'b00010,
        CIBS_S_ON   = 5'b00100,
        CIBS_S_BREC = 5'b01000,
        CIBS_S_BPWR = 5'b10000
    } cibs_state_t;
endpackage

// ==== logic/cibs_run_count.sv ====
`timescale 1ns/1ps
// counts consecutive recessive bits, pulses done after len of them
module cibs_run_count #(
    parameter int CW  = 4,
    parameter int LEN = 11
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic clr,
    input  wire logic bit_tick,
    input  wire logic rx_bit,
    output logic      done
);
    localparam logic [CW-1:0] LAST = CW'(LEN - 1);
    logic [CW-1:0] cnt_reg;

    // a dominant bit restarts the run
    always_ff @(posedge clk) begin
        if (sys_rst || clr) begin
            cnt_reg <= '0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (bit_tick) begin
                if (!rx_bit) begin
                    cnt_reg <= '0;
                end else if (cnt_reg == LAST) begin
                    cnt_reg <= '0;
                    done    <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 1'b1;
                end
            end
        end
    end
endmodule

// ==== logic/cibs_ctrl.sv ====
`timescale 1ns/1ps
module cibs_ctrl
    import cibs_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // special function register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    output logic [7:0]      sfr_rdata,
    // message memory write path
    input  wire logic       mem_wr,
    input  wire logic [7:0] mem_addr,
    input  wire logic [7:0] mem_wdata,
    output logic            mem_wr_out,
    output logic [7:0]      mem_addr_out,
    output logic [7:0]      mem_wdata_out,
    // protocol engine side
    input  wire logic       bit_tick,
    input  wire logic       rx_bit,
    input  wire logic       bus_busy,
    input  wire logic       bus_error,
    input  wire logic       tec_up,
    input  wire logic       tec_down,
    input  wire logic       rec_up,
    input  wire logic       rec_down,
    input  wire logic       rx_ok_stored,
    input  wire logic       rx_ok_any,
    input  wire logic       tx_ok,
    input  wire logic       powered_down,
    // interrupt enables from the core
    input  wire logic       can_irq_enable,
    input  wire logic       global_irq_enable,
    output logic            bus_enable,
    output logic            autobaud_mode,
    output logic            powerdown_request,
    output logic            can_irq
);
    ////////////////////////////////////////////////////////////////////
    logic [7:0]  ctrl_reg;
    logic [8:0]  tec_reg;
    logic [7:0]  rec_reg;
    logic [7:0]  bt0_reg;
    logic [7:0]  bt1_reg;
    logic        lock_req_reg;
    logic        exc_reg;
    logic        exc_next;
    logic        wake_reg;
    logic        rx_st_reg;
    logic        tx_st_reg;
    logic        pend_reg;
    logic [6:0]  grp_reg;
    logic [7:0]  ind_reg;
    cibs_state_t state_reg;
    cibs_state_t state_next;
    logic        run_done;
    logic        run_clr;
    logic        swinit;
    logic        busoff;
    logic        bt_zero;
    logic        soft_rst;
    logic        wr_ctrl;
    logic        wr_stat;
    logic        rd_stat;
    logic        rx_evt;
    logic        err_evt;
    logic        stat_evt;

    assign swinit   = (state_reg == CIBS_S_INIT);
    assign busoff   = (state_reg == CIBS_S_BREC) ||
                      (state_reg == CIBS_S_BPWR);
    assign bt_zero  = (bt0_reg == 8'h00) && (bt1_reg == 8'h00);
    assign soft_rst = ctrl_reg[CIBS_C_SOFT_RST];
    assign wr_ctrl  = sfr_wr && (sfr_addr == CIBS_CTRL_ADDR);
    assign wr_stat  = sfr_wr && (sfr_addr == CIBS_STATUS_ADDR);
    assign rd_stat  = sfr_rd && (sfr_addr == CIBS_STATUS_ADDR);
    // receive success source follows autobaud mode
    assign rx_evt   = ctrl_reg[CIBS_C_ABAUD] ? rx_ok_any : rx_ok_stored;

    ////////////////////////////////////////////////////////////////////
    // recessive run detector, restarted on every state change
    assign run_clr = (state_next != state_reg);

    cibs_run_count #(
        .CW  (4),
        .LEN (CIBS_IDLE_BITS)
    ) u_run (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .clr      (run_clr),
        .bit_tick (bit_tick),
        .rx_bit   (rx_bit),
        .done     (run_done)
    );

    ////////////////////////////////////////////////////////////////////
    // bus side state; bus-off outranks every other cause
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CIBS_S_INIT: begin
                // clear refused while timing is invalid
                if (wr_ctrl && !sfr_wdata[CIBS_C_SWI] && !bt_zero)
                    state_next = CIBS_S_SYNC;
            end
            CIBS_S_SYNC: begin
                if (lock_req_reg)
                    state_next = CIBS_S_INIT;
                else if (run_done)
                    state_next = CIBS_S_ON;
            end
            CIBS_S_ON: begin
                if (lock_req_reg && (!bus_busy || bus_error))
                    state_next = CIBS_S_INIT;
            end
            CIBS_S_BREC: begin
                if (run_done && grp_reg == 7'(CIBS_BOFF_GROUPS - 1))
                    state_next = CIBS_S_BPWR;
            end
            CIBS_S_BPWR: begin
                if (run_done)
                    state_next = CIBS_S_INIT;
            end
            default: state_next = CIBS_S_INIT;
        endcase
        if (!busoff && (soft_rst || bt_zero))
            state_next = CIBS_S_INIT;
        if (!busoff && tec_reg >= CIBS_TEC_BOFF)
            state_next = CIBS_S_BREC;
    end

    always_ff @(posedge clk) begin
        if (sys_rst)
            state_reg <= CIBS_S_INIT;
        else
            state_reg <= state_next;
    end

    // groups of 11 recessive bits during bus-off recovery
    always_ff @(posedge clk) begin
        if (sys_rst || state_reg != CIBS_S_BREC)
            grp_reg <= '0;
        else if (run_done)
            grp_reg <= grp_reg + 1'b1;
    end

    // pending init request; writes ignored in bus-off
    always_ff @(posedge clk) begin
        if (sys_rst || swinit || busoff)
            lock_req_reg <= 1'b0;
        else if (wr_ctrl && sfr_wdata[CIBS_C_SWI])
            lock_req_reg <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // control register; soft reset bit survives its own reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_reg <= CIBS_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_reg    <= sfr_wdata;
            ctrl_reg[4] <= 1'b0; // reserved, held low
            ctrl_reg[0] <= 1'b0; // init bit lives in the state machine
        end else if (soft_rst) begin
            ctrl_reg <= CIBS_CTRL_RST;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // error counters; engine counts only while on the bus
    always_ff @(posedge clk) begin
        if (sys_rst || soft_rst) begin
            tec_reg <= '0;
            rec_reg <= '0;
        end else if (state_reg == CIBS_S_BPWR && run_done) begin
            tec_reg <= '0;
            rec_reg <= '0;
        end else if (swinit && sfr_wr) begin
            if (sfr_addr == CIBS_TEC_ADDR)
                tec_reg <= {1'b0, sfr_wdata};
            if (sfr_addr == CIBS_REC_ADDR)
                rec_reg <= sfr_wdata;
        end else if (state_reg == CIBS_S_ON) begin
            if (tec_up)
                tec_reg <= tec_reg + 9'h008;
            else if (tec_down && tec_reg != 9'h000)
                tec_reg <= tec_reg - 9'h001;
            if (rec_up && rec_reg != 8'hff)
                rec_reg <= rec_reg + 8'h01;
            else if (rec_down && rec_reg != 8'h00)
                rec_reg <= rec_reg - 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // exceeded flag; select 0 holds between 96 and 97
    always_comb begin
        exc_next = exc_reg;
        if (ctrl_reg[CIBS_C_CNT_SEL]) begin
            exc_next = (tec_reg >= CIBS_LIM1) ||
                       ({1'b0, rec_reg} >= CIBS_LIM1);
        end else if (tec_reg >= CIBS_LIM0_SET ||
                     {1'b0, rec_reg} >= CIBS_LIM0_SET) begin
            exc_next = 1'b1;
        end else if (tec_reg < CIBS_LIM0_CLR &&
                     {1'b0, rec_reg} < CIBS_LIM0_CLR) begin
            exc_next = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst)
            exc_reg <= 1'b0;
        else
            exc_reg <= exc_next;
    end

    // wake flag follows power-down only while requested
    always_ff @(posedge clk) begin
        if (sys_rst)
            wake_reg <= 1'b0;
        else
            wake_reg <= ctrl_reg[CIBS_C_PWRDN] & powered_down;
    end

    ////////////////////////////////////////////////////////////////////
    // receive and transmit flags; hardware set beats host clear
    always_ff @(posedge clk) begin
        if (sys_rst || soft_rst) begin
            rx_st_reg <= 1'b0;
            tx_st_reg <= 1'b0;
        end else begin
            if (rx_evt)
                rx_st_reg <= 1'b1;
            else if (wr_stat)
                rx_st_reg <= sfr_wdata[CIBS_S_RX];
            if (tx_ok)
                tx_st_reg <= 1'b1;
            else if (wr_stat)
                tx_st_reg <= sfr_wdata[CIBS_S_TX];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // error and status events feeding the status change request
    always_comb begin
        err_evt = 1'b0;
        if (exc_next && !exc_reg)
            err_evt = 1'b1;
        if (!exc_next && exc_reg && ctrl_reg[CIBS_C_CNT_SEL])
            err_evt = 1'b1;
        if (state_next == CIBS_S_BREC && !busoff)
            err_evt = 1'b1;
        err_evt = err_evt & ctrl_reg[CIBS_C_ERR_IE];
        stat_evt = rx_evt || tx_ok;
        if (wr_stat && sfr_wdata[CIBS_S_RX] && !rx_st_reg)
            stat_evt = 1'b1;
        if (wr_stat && sfr_wdata[CIBS_S_TX] && !tx_st_reg)
            stat_evt = 1'b1;
        if (wake_reg && !(ctrl_reg[CIBS_C_PWRDN] & powered_down))
            stat_evt = 1'b1;
        stat_evt = stat_evt & ctrl_reg[CIBS_C_STAT_IE];
    end

    // a new event in the read cycle is kept, not lost
    always_ff @(posedge clk) begin
        if (sys_rst || soft_rst)
            pend_reg <= 1'b0;
        else if (err_evt || stat_evt)
            pend_reg <= 1'b1;
        else if (rd_stat)
            pend_reg <= 1'b0;
    end

    // message centers are outside, so only 00h or 01h appear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ind_reg <= CIBS_IND_NONE;
            can_irq <= 1'b0;
        end else begin
            ind_reg <= pend_reg ? CIBS_IND_STAT : CIBS_IND_NONE;
            can_irq <= pend_reg & can_irq_enable & global_irq_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // message memory: low bytes locked outside init, reads untouched
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mem_wr_out    <= 1'b0;
            mem_addr_out  <= 8'h00;
            mem_wdata_out <= 8'h00;
        end else begin
            mem_wr_out    <= mem_wr &&
                             (swinit || mem_addr >= CIBS_MEM_PROT_LIM);
            mem_addr_out  <= mem_addr;
            mem_wdata_out <= mem_wdata;
        end
    end

    // shadow of the timing bytes, zero after reset as in memory
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bt0_reg <= 8'h00;
            bt1_reg <= 8'h00;
        end else if (mem_wr && swinit) begin
            if (mem_addr == CIBS_BT0_ADDR)
                bt0_reg <= mem_wdata;
            if (mem_addr == CIBS_BT1_ADDR)
                bt1_reg <= mem_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data, one cycle after the strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            case (sfr_addr)
                CIBS_CTRL_ADDR:   sfr_rdata <= {ctrl_reg[7:1], swinit};
                CIBS_STATUS_ADDR: sfr_rdata <= {busoff, exc_reg, wake_reg,
                                                rx_st_reg, tx_st_reg, 3'b000};
                CIBS_IND_ADDR:    sfr_rdata <= ind_reg;
                CIBS_TEC_ADDR:    sfr_rdata <= tec_reg[7:0];
                CIBS_REC_ADDR:    sfr_rdata <= rec_reg;
                default:          sfr_rdata <= 8'h00;
            endcase
        end
    end

    // engine controls; in init or bus-off the node stays silent
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_enable        <= 1'b0;
            autobaud_mode     <= 1'b0;
            powerdown_request <= 1'b0;
        end else begin
            bus_enable        <= (state_next == CIBS_S_ON);
            autobaud_mode     <= ctrl_reg[CIBS_C_ABAUD];
            powerdown_request <= ctrl_reg[CIBS_C_PWRDN];
        end
    end
endmodule

// ==== tb/cibs_ctrl_chk.sv ====
`timescale 1ns/1ps
module cibs_ctrl_chk
    import cibs_pkg::*;
(
    input logic       clk,
    input logic       sys_rst,
    input logic [7:0] sfr_addr,
    input logic       sfr_wr,
    input logic       sfr_rd,
    input logic [7:0] sfr_rdata,
    input logic       mem_wr,
    input logic [7:0] mem_addr,
    input logic [7:0] mem_wdata,
    input logic       mem_wr_out,
    input logic [7:0] mem_addr_out,
    input logic [7:0] mem_wdata_out,
    input logic       bit_tick,
    input logic       rx_bit,
    input logic       tec_up,
    input logic       tec_down,
    input logic       rx_ok_stored,
    input logic       rx_ok_any,
    input logic       tx_ok,
    input logic       can_irq_enable,
    input logic       global_irq_enable,
    input logic       bus_enable,
    input logic       can_irq
);
    logic [11:0] run_cnt;
    logic        quiet;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////
    // recessive sample points in a row, saturating
    always_ff @(posedge clk) begin
        if (sys_rst || (bit_tick && !rx_bit)) begin
            run_cnt <= 12'h000;
        end else if (bit_tick && run_cnt != 12'hfff) begin
            run_cnt <= run_cnt + 12'h001;
        end
    end
    // no transmit count, receive success, transmit or register write event this cycle
    assign quiet = !(tec_up || tec_down || rx_ok_stored || rx_ok_any
                     || tx_ok || sfr_wr);
    ////////////////////////////////////////////////////////////
    a_rst_quiet: assert property ($fell(sys_rst) |->
        !bus_enable && !can_irq && !mem_wr_out) else $error("not idle");
    a_join_wait: assert property ($rose(bus_enable) |->
        run_cnt >= 12'd11) else $error("joined bus too early");
    a_mem_open: assert property (mem_wr && mem_addr >= CIBS_MEM_PROT_LIM
        |=> mem_wr_out && mem_addr_out == $past(mem_addr)
        && mem_wdata_out == $past(mem_wdata)) else $error("open write lost");
    a_mem_lock: assert property (mem_wr && mem_addr < CIBS_MEM_PROT_LIM
        && bus_enable |=> !mem_wr_out || !bus_enable)
        else $error("locked write passed");
    a_mem_idle: assert property (!mem_wr |=> !mem_wr_out)
        else $error("write without request");
    a_irq_gate: assert property (can_irq |-> $past(can_irq_enable)
        && $past(global_irq_enable)) else $error("irq while disabled");
    // the read is taken on one edge, the request line drops one later
    a_stat_clear: assert property ($past(quiet) && sfr_rd && quiet
        && sfr_addr == CIBS_STATUS_ADDR ##1 quiet |=> !can_irq)
        else $error("status read left irq pending");
    a_rd_unmapped: assert property (sfr_rd && (sfr_addr < CIBS_CTRL_ADDR
        || sfr_addr > CIBS_REC_ADDR) |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rd_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
        else $error("read data moved");
endmodule

// ==== tb/cibs_bus_model.sv ====
`timescale 1ns/1ps
module cibs_bus_model (
    input  logic clk,
    input  logic hold_dom,
    output logic bit_tick,
    output logic rx_bit
);
    logic [1:0] div_reg = 2'd0;
    ////////////////////////////////////////////////////////////
    // one sample point every fourth clock keeps long recessive runs short
    always_ff @(posedge clk) begin
        div_reg <= div_reg + 2'd1;
    end
    assign bit_tick = (div_reg == 2'd3);
    // recessive is the released level of the wire
    assign rx_bit = !hold_dom;
endmodule

// ==== tb/cibs_ctrl_tb_top.sv ====
`timescale 1ns/1ps
module cibs_ctrl_tb_top
    import cibs_pkg::*;
;
    logic       clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic       sfr_wr = 1'b0;
    logic       sfr_rd = 1'b0;
    logic [7:0] mem_addr = 8'h00;
    logic       mem_wr = 1'b0;
    logic [7:0] ev = 8'h00;
    logic       bus_busy = 1'b0;
    logic       hold_dom = 1'b0;
    logic       pwr_dn = 1'b0;
    logic       ab_mode, pd_req;
    logic [7:0] sfr_rdata, mem_addr_out, mem_wdata_out, d;
    logic       mem_wr_out, bit_tick, rx_bit, bus_enable, can_irq;
    int         n_mismatch = 0;
    int         checks_done = 0;
    int         cyc = 0;
    ////////////////////////////////////////////////////////////
    always #10 clk = ~clk;
    // event pulses share one vector so a single task drives them all
    cibs_ctrl u_cibs_ctrl (.clk(clk), .sys_rst(sys_rst),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .mem_wr(mem_wr),
        .mem_addr(mem_addr), .mem_wdata(mem_addr ^ 8'h5a),
        .mem_wr_out(mem_wr_out), .mem_addr_out(mem_addr_out),
        .mem_wdata_out(mem_wdata_out), .bit_tick(bit_tick),
        .rx_bit(rx_bit), .bus_busy(bus_busy), .bus_error(ev[7]),
        .tec_up(ev[0]), .tec_down(ev[1]), .rec_up(ev[2]),
        .rec_down(ev[3]), .rx_ok_stored(ev[4]), .rx_ok_any(ev[5]),
        .tx_ok(ev[6]), .powered_down(pwr_dn), .can_irq_enable(1'b1),
        .global_irq_enable(1'b1), .bus_enable(bus_enable),
        .autobaud_mode(ab_mode), .powerdown_request(pd_req),
        .can_irq(can_irq));
    cibs_bus_model u_cibs_bus_model (.clk(clk), .hold_dom(hold_dom),
        .bit_tick(bit_tick), .rx_bit(rx_bit));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        sfr_addr  <= a;
        sfr_wdata <= v;
        sfr_wr    <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1 d = sfr_rdata;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        rd(a);
        chk(d, exp);
    endtask
    task automatic mw(input logic [7:0] a, input logic exp);
        @(posedge clk);
        mem_addr <= a;
        mem_wr   <= 1'b1;
        @(posedge clk);
        mem_wr <= 1'b0;
        #1 chk({7'h00, mem_wr_out}, {7'h00, exp});
    endtask
    // settle time lets status, pending and the irq line all land
    task automatic pulse(input int i, input int n);
        repeat (n) begin
            @(posedge clk);
            ev[i] <= 1'b1;
            @(posedge clk);
            ev[i] <= 1'b0;
        end
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic wait_en;
        for (int k = 0; k < 200 && bus_enable !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        chk({7'h00, bus_enable}, 8'h01);
    endtask
    task automatic final_report;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // the sequence needs about 6300 cycles; stop a hang well after
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        rd(CIBS_CTRL_ADDR);
        chk({7'h00, d[CIBS_C_SWI]}, 8'h01);
        wr(CIBS_CTRL_ADDR, 8'h01);
        wr(CIBS_CTRL_ADDR, 8'h00);
        rd(CIBS_CTRL_ADDR);
        chk({7'h00, d[CIBS_C_SWI]}, 8'h01);
        rc(8'h50, 8'h00);
        mw(CIBS_BT0_ADDR, 1'b1);
        mw(CIBS_BT1_ADDR, 1'b1);
        wr(CIBS_TEC_ADDR, 8'h05);
        rc(CIBS_TEC_ADDR, 8'h05);
        wr(CIBS_TEC_ADDR, 8'h00);
        // a dominant stretch must hold off joining the bus
        hold_dom <= 1'b1;
        wr(CIBS_CTRL_ADDR, 8'h00);
        repeat (100) @(posedge clk);
        #1 chk({7'h00, bus_enable}, 8'h00);
        hold_dom <= 1'b0;
        wait_en();
        mw(8'h03, 1'b0);
        mw(8'h20, 1'b1);
        wr(CIBS_TEC_ADDR, 8'h55);
        rc(CIBS_TEC_ADDR, 8'h00);
        wr(CIBS_CTRL_ADDR, 8'h40);
        pulse(5, 1);
        rc(CIBS_STATUS_ADDR, 8'h00);
        pulse(4, 1);
        chk({7'h00, can_irq}, 8'h01);
        rc(CIBS_IND_ADDR, 8'h01);
        rc(CIBS_STATUS_ADDR, 8'h10);
        rc(CIBS_IND_ADDR, 8'h00);
        pulse(4, 1);
        rc(CIBS_IND_ADDR, 8'h01);
        rc(CIBS_STATUS_ADDR, 8'h10);
        pulse(6, 1);
        rc(CIBS_IND_ADDR, 8'h01);
        rc(CIBS_STATUS_ADDR, 8'h18);
        wr(CIBS_STATUS_ADDR, 8'h00);
        rc(CIBS_STATUS_ADDR, 8'h00);
        wr(CIBS_STATUS_ADDR, 8'h10);
        rc(CIBS_IND_ADDR, 8'h01);
        rc(CIBS_STATUS_ADDR, 8'h10);
        wr(CIBS_STATUS_ADDR, 8'h10);
        rc(CIBS_IND_ADDR, 8'h00);
        wr(CIBS_STATUS_ADDR, 8'h18);
        rc(CIBS_IND_ADDR, 8'h01);
        rc(CIBS_STATUS_ADDR, 8'h18);
        wr(CIBS_CTRL_ADDR, 8'h44);
        wr(CIBS_STATUS_ADDR, 8'h00);
        pulse(5, 1);
        rc(CIBS_STATUS_ADDR, 8'h10);
        chk({7'h00, ab_mode}, 8'h01);
        wr(CIBS_STATUS_ADDR, 8'h00);
        // power-down shows wake status; leaving it raises a request
        wr(CIBS_CTRL_ADDR, 8'h60);
        pwr_dn <= 1'b1;
        rc(CIBS_STATUS_ADDR, 8'h20);
        chk({7'h00, pd_req}, 8'h01);
        wr(CIBS_CTRL_ADDR, 8'h40);
        repeat (2) @(posedge clk);
        rc(CIBS_IND_ADDR, 8'h01);
        rc(CIBS_STATUS_ADDR, 8'h00);
        pwr_dn <= 1'b0;
        // error counts: +8 per transmit error
        wr(CIBS_CTRL_ADDR, 8'h80);
        pulse(0, 12);
        rc(CIBS_STATUS_ADDR, 8'h00);
        pulse(0, 1);
        rc(CIBS_IND_ADDR, 8'h01);
        rc(CIBS_STATUS_ADDR, 8'h40);
        wr(CIBS_CTRL_ADDR, 8'h82);
        rc(CIBS_STATUS_ADDR, 8'h00);
        pulse(0, 3);
        rc(CIBS_STATUS_ADDR, 8'h40);
        pulse(1, 1);
        rc(CIBS_IND_ADDR, 8'h01);
        rc(CIBS_STATUS_ADDR, 8'h00);
        pulse(0, 16);
        rc(CIBS_STATUS_ADDR, 8'h40);
        pulse(0, 1);
        chk({7'h00, bus_enable}, 8'h00);
        rc(CIBS_IND_ADDR, 8'h01);
        rc(CIBS_STATUS_ADDR, 8'hc0);
        rc(CIBS_CTRL_ADDR, 8'h82);
        wr(CIBS_CTRL_ADDR, 8'h83);
        rc(CIBS_CTRL_ADDR, 8'h82);
        // recovery takes 1419 sample points of four clocks each
        repeat (5500) @(posedge clk);
        rc(CIBS_STATUS_ADDR, 8'hc0);
        repeat (300) @(posedge clk);
        rc(CIBS_STATUS_ADDR, 8'h00);
        rc(CIBS_CTRL_ADDR, 8'h83);
        rc(CIBS_TEC_ADDR, 8'h00);
        rc(CIBS_REC_ADDR, 8'h00);
        wr(CIBS_CTRL_ADDR, 8'h82);
        wait_en();
        @(posedge clk);
        bus_busy <= 1'b1;
        wr(CIBS_CTRL_ADDR, 8'h83);
        rc(CIBS_CTRL_ADDR, 8'h82);
        chk({7'h00, bus_enable}, 8'h01);
        @(posedge clk);
        bus_busy <= 1'b0;
        repeat (3) @(posedge clk);
        rc(CIBS_CTRL_ADDR, 8'h83);
        chk({7'h00, bus_enable}, 8'h00);
        // an error on the bus also lets the pending init request through
        wr(CIBS_CTRL_ADDR, 8'h82);
        wait_en();
        bus_busy <= 1'b1;
        wr(CIBS_CTRL_ADDR, 8'h83);
        pulse(7, 1);
        rc(CIBS_CTRL_ADDR, 8'h83);
        chk({7'h00, bus_enable}, 8'h00);
        final_report();
    end
endmodule

bind cibs_ctrl cibs_ctrl_chk u_cibs_ctrl_chk (.clk(clk), .sys_rst(sys_rst),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_wr_out(mem_wr_out),
    .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
    .bit_tick(bit_tick), .rx_bit(rx_bit), .tec_up(tec_up),
    .tec_down(tec_down), .rx_ok_stored(rx_ok_stored),
    .rx_ok_any(rx_ok_any), .tx_ok(tx_ok), .can_irq_enable(can_irq_enable),
    .global_irq_enable(global_irq_enable), .bus_enable(bus_enable),
    .can_irq(can_irq));
